/* File: test_uvfc_ctrl.sv */
`timescale 1ns/10ps
module test_uvfc_ctrl;
    import uvfc_pkg::*;
    logic        mclk_i = 1'b0, reset_n_i = 1'b0;
    logic [11:0] avs_address_i = '0;
    logic        avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
    logic [31:0] avs_writedata_i = '0, avs_readdata_o;
    logic        frame_valid_i = 1'b0, unk_vlan_i = 1'b0, unk_ucast_i = 1'b0, unk_mcast_i = 1'b0;
    logic [15:0] ethertype_i = '0, actual_len_i = '0;
    logic [47:0] dest_addr_i = '0;
    logic        half_duplex_i = 1'b0, back_pressure_i = 1'b0;
    logic [4:0]  collision_count_i = '0;
    logic        result_valid_o, drop_o, alt_backoff_o, aggr_backoff_o, xcol_drop_o;
    logic [2:0]  port_mask_o;
    int          error_cnt = 0, cmp_count = 0;
    int unsigned m[7] = '{0, 0, 0, 0, 'hf00e, 0, 0};
    logic [11:0] adr[8] = '{12'h328, 12'h330, 12'h320, 12'h324, 12'h334, 12'h32c, 12'h000, 12'h33c};

    always #12.5 mclk_i = ~mclk_i;

    uvfc_ctrl #(.PORTS(3)) dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .frame_valid_i(frame_valid_i), .unk_vlan_i(unk_vlan_i), .unk_ucast_i(unk_ucast_i),
        .unk_mcast_i(unk_mcast_i), .ethertype_i(ethertype_i), .dest_addr_i(dest_addr_i),
        .actual_len_i(actual_len_i), .half_duplex_i(half_duplex_i),
        .back_pressure_i(back_pressure_i), .collision_count_i(collision_count_i),
        .result_valid_o(result_valid_o), .drop_o(drop_o), .port_mask_o(port_mask_o),
        .alt_backoff_o(alt_backoff_o), .aggr_backoff_o(aggr_backoff_o),
        .xcol_drop_o(xcol_drop_o));

    // ----------------------------
    // Compare, bus and frame tasks
    // ----------------------------
    task automatic results();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_frm(input string nm, input logic [4:0] e, input logic [4:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk_i);
        {avs_address_i, avs_write_i, avs_read_i, avs_writedata_i} <= {a, w, !w, d};
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        {avs_write_i, avs_read_i} <= 2'b00;
        if (n >= 50) begin
            error_cnt++;
            results();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        int          x;
        x = (int'(a) - 'h320) / 4;
        if (x == 4 && d[11]) d[7] = 1'b1;
        bus(1'b1, a, d, q);
        if (x inside {[0:2]}) m[x] = d & 32'h8000_0007;
        if (x == 4) m[x] = d & 32'hffff;
    endtask

    task automatic rd(input logic [11:0] a);
        logic [31:0] q;
        int          x;
        x = (int'(a) - 'h320) / 4;
        bus(1'b0, a, '0, q);
        chk_reg("readdata", (x inside {[0:6]}) ? m[x] : 0, q);
    endtask

    task automatic frame(input logic [2:0] c, input logic [15:0] et, input logic [47:0] da,
                         input logic [15:0] ln);
        logic [31:0] r;
        logic [2:0]  pm;
        logic [4:0]  cc;
        logic        dr, hd, bp, fe, fd;
        {hd, bp, cc} = 7'($urandom);
        @(posedge mclk_i);
        {frame_valid_i, unk_mcast_i, unk_ucast_i, unk_vlan_i} <= {1'b1, c};
        {ethertype_i, dest_addr_i, actual_len_i} <= {et, da, ln};
        {half_duplex_i, back_pressure_i, collision_count_i} <= {hd, bp, cc};
        @(posedge mclk_i);
        frame_valid_i <= 1'b0;
        @(posedge mclk_i);
        // Vlan first, then unicast, then multicast
        r = c[0] ? m[2] : c[1] ? m[0] : m[1];
        dr = c != 0 && (!r[31] || r[2:0] == 0);
        pm = c != 0 ? r[2:0] : 3'h7;
        fe = et == 16'h8808;
        fd = da == 48'h0180_c200_0001;
        if (m[4][1] ? fe | fd : fe & fd) dr = 1'b1;
        if (m[4][3] && et < 16'd1500 && et != ln) dr = 1'b1;
        if (dr) pm = 3'h0;
        m[6] = {13'h0, c[0] ? 3'h1 : c[1] ? 3'h2 : c[2] ? 3'h4 : 3'h0, m[6][15:0] + 16'(dr)};
        chk_frm("decision", {1'b1, dr, pm}, {result_valid_o, drop_o, port_mask_o});
        chk_frm("backoff", {2'b00, m[4][7] & hd, m[4][0] & hd & bp, cc >= 5'd16 && !m[4][11]},
                {2'b00, alt_backoff_o, aggr_backoff_o, xcol_drop_o});
    endtask

    // ----------------------------
    // Test sequence
    // ----------------------------
    initial begin
        #(25 * 20000);
        error_cnt++;
        results();
    end

    initial begin
        int          i;
        logic [15:0] et;
        void'($urandom(32'h268b));
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        for (i = 0; i < 8; i++) rd(adr[i]);
        for (i = 0; i < 8; i++) begin
            wr(adr[i], $urandom);
            rd(adr[i]);
        end
        for (i = 0; i < 16; i++) begin
            wr(12'h328, {i[3], 28'h0, i[2:0]});
            frame(3'b001, 16'h0800, 48'h1, 16'h0);
        end
        for (i = 0; i < 400; i++) begin
            if ($urandom % 4 == 0) wr(adr[$urandom % 5], $urandom);
            case ($urandom % 4)
                0: et = 16'h8808;
                1: et = 16'd1499 + 16'($urandom % 2);
                2: et = 16'($urandom % 1500);
                default: et = 16'h0800;
            endcase
            frame(3'($urandom), et, ($urandom % 2) ? 48'h0180_c200_0001 : {$urandom, 16'h0180},
                  ($urandom % 2) ? et : 16'($urandom % 1500));
        end
        rd(12'h338);
        results();
    end
endmodule

/* File: uvfc_ctrl.sv */
`timescale 1ns/10ps
// How it works
// - Bit 31 of the unknown-VLAN register enables forwarding of unknown-VLAN frames.
// - Mask bits 2..0 of that register pick ports 3..1 as destinations.
// - Control 0 bit 7 turns on alternate back-off, effective in half duplex only.
// - Control 0 bit 3 drops frames whose length field below 1500 mismatches real length.
// - With control 0 bit 1 set, a pause EtherType or pause address alone drops a frame.
// - With that bit clear, only both pause EtherType and pause address together drop.
// - Control 0 bit 0 turns on aggressive back-off under half-duplex back pressure.
// - Unknown VLAN beats unknown unicast, which beats unknown multicast.
// - With no-excessive-collision-drop set, frames with 16+ collisions are kept.
module uvfc_ctrl
    import uvfc_pkg::*;
#(
    parameter int PORTS = 3
) (
    input  wire logic             mclk_i,
    input  wire logic             reset_n_i,
    // Avalon-MM slave
    input  wire logic [11:0]      avs_address_i,
    input  wire logic             avs_read_i,
    input  wire logic             avs_write_i,
    input  wire logic [31:0]      avs_writedata_i,
    input  wire logic [3:0]       avs_byteenable_i,
    output logic [31:0]           avs_readdata_o,
    output logic                  avs_waitrequest_o,
    // Frame classification from the parser
    input  wire logic             frame_valid_i,
    input  wire logic             unk_vlan_i,
    input  wire logic             unk_ucast_i,
    input  wire logic             unk_mcast_i,
    input  wire logic [15:0]      ethertype_i,
    input  wire logic [47:0]      dest_addr_i,
    input  wire logic [15:0]      actual_len_i,
    // Half-duplex MAC status
    input  wire logic             half_duplex_i,
    input  wire logic             back_pressure_i,
    input  wire logic [4:0]       collision_count_i,
    // Decisions
    output logic                  result_valid_o,
    output logic                  drop_o,
    output logic [PORTS-1:0]      port_mask_o,
    output logic                  alt_backoff_o,
    output logic                  aggr_backoff_o,
    output logic                  xcol_drop_o
);

    initial begin
        if (PORTS != 3) $error("uvfc_ctrl serves three ports only");
    end

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [31:0] vlan_ctrl;
    logic [31:0] ucast_ctrl;
    logic [31:0] mcast_ctrl;
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [15:0] drop_count;
    logic [2:0]  last_cat;
    logic        ack;
    logic [31:0] next_vlan_ctrl;
    logic [31:0] next_ucast_ctrl;
    logic [31:0] next_mcast_ctrl;
    logic [7:0]  next_ctrl0;
    logic [7:0]  next_ctrl1;
    logic [15:0] next_drop_count;
    logic [2:0]  next_last_cat;
    logic        next_ack;
    logic [31:0] next_readdata;
    logic        dec_valid;
    logic        dec_drop;
    logic [2:0]  dec_cat;

    // Only bit 31 and the port mask are writable in the mask registers
    function automatic logic [31:0] unk_write(input logic [31:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
        unk_write = old_v;
        if (be[3]) unk_write[31] = wd[31];
        if (be[0]) unk_write[2:0] = wd[2:0];
    endfunction

    // ----------------------------------------------------------------
    // Bus slave: one wait cycle, answer on the second edge
    // ----------------------------------------------------------------
    always_comb begin
        next_vlan_ctrl  = vlan_ctrl;
        next_ucast_ctrl = ucast_ctrl;
        next_mcast_ctrl = mcast_ctrl;
        next_ctrl0      = ctrl0;
        next_ctrl1      = ctrl1;
        next_readdata   = avs_readdata_o;
        next_ack        = (avs_read_i || avs_write_i) && !ack;
        if (avs_write_i && !ack) begin
            unique case (avs_address_i)
                UVFC_ADDR_UNK_VLAN: begin
                    next_vlan_ctrl = unk_write(vlan_ctrl, avs_writedata_i,
                                               avs_byteenable_i);
                end
                UVFC_ADDR_UNK_UCAST: begin
                    next_ucast_ctrl = unk_write(ucast_ctrl, avs_writedata_i,
                                                avs_byteenable_i);
                end
                UVFC_ADDR_UNK_MCAST: begin
                    next_mcast_ctrl = unk_write(mcast_ctrl, avs_writedata_i,
                                                avs_byteenable_i);
                end
                UVFC_ADDR_MAC_CTRL0: begin
                    if (avs_byteenable_i[0]) next_ctrl0 = avs_writedata_i[7:0];
                    if (avs_byteenable_i[UVFC_CTRL1_LANE]) begin
                        next_ctrl1 = avs_writedata_i[UVFC_CTRL1_LSB +: 8];
                    end
                end
                default: begin
                end
            endcase
        end
        if (avs_read_i && !ack) begin
            unique case (avs_address_i)
                UVFC_ADDR_UNK_VLAN:   next_readdata = vlan_ctrl;
                UVFC_ADDR_UNK_UCAST:  next_readdata = ucast_ctrl;
                UVFC_ADDR_UNK_MCAST:  next_readdata = mcast_ctrl;
                UVFC_ADDR_MAC_CTRL0: begin
                    next_readdata                      = {24'h000000, ctrl0};
                    next_readdata[UVFC_CTRL1_LSB +: 8] = ctrl1;
                end
                UVFC_ADDR_FRAME_STAT: next_readdata = {13'h0000, last_cat, drop_count};
                default:              next_readdata = UVFC_UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vlan_ctrl         <= UVFC_UNK_RST;
            ucast_ctrl        <= UVFC_UNK_RST;
            mcast_ctrl        <= UVFC_UNK_RST;
            ctrl0             <= UVFC_CTRL0_RST;
            ctrl1             <= UVFC_CTRL1_RST;
            ack               <= 1'b0;
            avs_readdata_o    <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
        end else begin
            vlan_ctrl         <= next_vlan_ctrl;
            ucast_ctrl        <= next_ucast_ctrl;
            mcast_ctrl        <= next_mcast_ctrl;
            ctrl0             <= next_ctrl0;
            ctrl1             <= next_ctrl1;
            ack               <= next_ack;
            avs_readdata_o    <= next_readdata;
            avs_waitrequest_o <= !next_ack;
        end
    end

    // ----------------------------------------------------------------
    // Frame decision
    // ----------------------------------------------------------------
    uvfc_frame_decide #(
        .PORTS (PORTS)
    ) u_decide (
        .mclk_i         (mclk_i),
        .reset_n_i      (reset_n_i),
        .frame_valid_i  (frame_valid_i),
        .unk_vlan_i     (unk_vlan_i),
        .unk_ucast_i    (unk_ucast_i),
        .unk_mcast_i    (unk_mcast_i),
        .ethertype_i    (ethertype_i),
        .dest_addr_i    (dest_addr_i),
        .actual_len_i   (actual_len_i),
        .vlan_ctrl_i    (vlan_ctrl),
        .ucast_ctrl_i   (ucast_ctrl),
        .mcast_ctrl_i   (mcast_ctrl),
        .ctrl0_i        (ctrl0),
        .result_valid_o (dec_valid),
        .drop_o         (dec_drop),
        .port_mask_o    (port_mask_o),
        .category_o     (dec_cat)
    );

    assign result_valid_o = dec_valid;
    assign drop_o         = dec_drop;

    // ----------------------------------------------------------------
    // Drop statistics and back-off controls
    // ----------------------------------------------------------------
    logic next_alt;
    logic next_aggr;
    logic next_xcol;

    always_comb begin
        next_drop_count = drop_count;
        next_last_cat   = last_cat;
        if (dec_valid) begin
            next_last_cat = dec_cat;
            // Saturates so software never sees a wrap
            if (dec_drop && drop_count != 16'hffff) begin
                next_drop_count = drop_count + 16'h0001;
            end
        end
        // Back-off modes only matter on half-duplex links
        next_alt  = ctrl0[UVFC_ALT_BACKOFF_BIT] && half_duplex_i;
        next_aggr = ctrl0[UVFC_AGGR_BACKOFF_BIT] && half_duplex_i
                    && back_pressure_i;
        next_xcol = (collision_count_i >= UVFC_XCOL_LIMIT)
                    && !ctrl1[UVFC_NO_XCOL_DROP_BIT];
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drop_count     <= 16'h0000;
            last_cat       <= 3'b000;
            alt_backoff_o  <= 1'b0;
            aggr_backoff_o <= 1'b0;
            xcol_drop_o    <= 1'b0;
        end else begin
            drop_count     <= next_drop_count;
            last_cat       <= next_last_cat;
            alt_backoff_o  <= next_alt;
            aggr_backoff_o <= next_aggr;
            xcol_drop_o    <= next_xcol;
        end
    end

endmodule

/* File: uvfc_ctrl_properties.sv */
`timescale 1ns/10ps
module uvfc_ctrl_checker
    import uvfc_pkg::*;
#(
    parameter int PORTS = 3
) (
    input wire logic             mclk_i,
    input wire logic             reset_n_i,
    input wire logic [11:0]      avs_address_i,
    input wire logic             avs_read_i,
    input wire logic             avs_write_i,
    input wire logic [31:0]      avs_readdata_o,
    input wire logic             avs_waitrequest_o,
    input wire logic             frame_valid_i,
    input wire logic [15:0]      ethertype_i,
    input wire logic [47:0]      dest_addr_i,
    input wire logic             half_duplex_i,
    input wire logic [4:0]       collision_count_i,
    input wire logic             result_valid_o,
    input wire logic             drop_o,
    input wire logic [PORTS-1:0] port_mask_o,
    input wire logic             alt_backoff_o,
    input wire logic             xcol_drop_o
);
    // ----------------------------
    // Bus and decision checks
    // ----------------------------
    default clocking dc @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    logic req;
    logic rd_ack;
    assign req    = avs_read_i | avs_write_i;
    assign rd_ack = avs_read_i & ~avs_waitrequest_o;

    property p_wait_ans; req && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
    property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o ##1 $stable(avs_readdata_o); endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer not one cycle");
    property p_rd_res; rd_ack && avs_address_i == UVFC_ADDR_UNK_VLAN |-> avs_readdata_o[30:3] == '0;
    endproperty
    a_rd_res: assert property (p_rd_res) else $error("reserved bits not zero");
    property p_unmap; rd_ack && avs_address_i[1:0] == 2'h0 && (avs_address_i < 12'h320
        || avs_address_i > 12'h338 || avs_address_i == 12'h32c || avs_address_i == 12'h334)
        |-> avs_readdata_o == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_res_lat; frame_valid_i |=> result_valid_o ##1 !result_valid_o; endproperty
    a_res_lat: assert property (p_res_lat) else $error("result latency wrong");
    property p_drop_mask; result_valid_o && drop_o |-> port_mask_o == '0; endproperty
    a_drop_mask: assert property (p_drop_mask) else $error("dropped frame has ports");
    property p_fc_both; frame_valid_i && ethertype_i == UVFC_FC_ETHERTYPE
        && dest_addr_i == UVFC_FC_DA |=> drop_o; endproperty
    a_fc_both: assert property (p_fc_both) else $error("pause frame kept");
    property p_alt; alt_backoff_o |-> $past(half_duplex_i); endproperty
    a_alt: assert property (p_alt) else $error("alternate back-off in full duplex");
    property p_xcol; xcol_drop_o |-> $past(collision_count_i) >= UVFC_XCOL_LIMIT; endproperty
    a_xcol: assert property (p_xcol) else $error("collision drop below limit");
endmodule

bind uvfc_ctrl uvfc_ctrl_checker #(.PORTS(PORTS)) u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .frame_valid_i(frame_valid_i), .ethertype_i(ethertype_i), .dest_addr_i(dest_addr_i),
    .half_duplex_i(half_duplex_i), .collision_count_i(collision_count_i),
    .result_valid_o(result_valid_o), .drop_o(drop_o), .port_mask_o(port_mask_o),
    .alt_backoff_o(alt_backoff_o), .xcol_drop_o(xcol_drop_o));

/* File: uvfc_frame_decide.sv */
`timescale 1ns/10ps
module uvfc_frame_decide
    import uvfc_pkg::*;
#(
    parameter int PORTS = 3
) (
    input  wire logic             mclk_i,
    input  wire logic             reset_n_i,
    input  wire logic             frame_valid_i,
    input  wire logic             unk_vlan_i,
    input  wire logic             unk_ucast_i,
    input  wire logic             unk_mcast_i,
    input  wire logic [15:0]      ethertype_i,
    input  wire logic [47:0]      dest_addr_i,
    input  wire logic [15:0]      actual_len_i,
    input  wire logic [31:0]      vlan_ctrl_i,
    input  wire logic [31:0]      ucast_ctrl_i,
    input  wire logic [31:0]      mcast_ctrl_i,
    input  wire logic [7:0]       ctrl0_i,
    output logic                  result_valid_o,
    output logic                  drop_o,
    output logic [PORTS-1:0]      port_mask_o,
    output logic [2:0]            category_o
);

    initial begin
        if (PORTS != 3) $error("uvfc_frame_decide serves three ports only");
    end

    // ----------------------------------------------------------------
    // Category forwarding decision
    // ----------------------------------------------------------------
    function automatic logic [PORTS-1:0] fwd_ports(input logic [31:0] ctrl);
        fwd_ports = ctrl[UVFC_FWD_EN_BIT] ? ctrl[PORTS-1:0] : '0;
    endfunction

    logic             fc_type;
    logic             fc_da;
    logic             next_valid;
    logic             next_drop;
    logic [PORTS-1:0] next_mask;
    logic [2:0]       next_cat;

    always_comb begin
        fc_type    = (ethertype_i == UVFC_FC_ETHERTYPE);
        fc_da      = (dest_addr_i == UVFC_FC_DA);
        next_valid = frame_valid_i;
        next_drop  = 1'b0;
        next_mask  = {PORTS{1'b1}};
        next_cat   = 3'b000;
        // Precedence: unknown VLAN, then unicast, then multicast
        if (unk_vlan_i) begin
            next_cat  = UVFC_CAT_VLAN;
            next_mask = fwd_ports(vlan_ctrl_i);
        end else if (unk_ucast_i) begin
            next_cat  = UVFC_CAT_UCAST;
            next_mask = fwd_ports(ucast_ctrl_i);
        end else if (unk_mcast_i) begin
            next_cat  = UVFC_CAT_MCAST;
            next_mask = fwd_ports(mcast_ctrl_i);
        end
        if (next_cat != 3'b000 && next_mask == '0) begin
            next_drop = 1'b1;
        end
        if (ctrl0_i[UVFC_FC_DROP_MODE_BIT]) begin
            if (fc_type || fc_da) next_drop = 1'b1;
        end else begin
            if (fc_type && fc_da) next_drop = 1'b1;
        end
        if (ctrl0_i[UVFC_LEN_CHECK_BIT] && ethertype_i < UVFC_LEN_LIMIT
                && ethertype_i != actual_len_i) begin
            next_drop = 1'b1;
        end
        if (next_drop) next_mask = '0;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_valid_o <= 1'b0;
            drop_o         <= 1'b0;
            port_mask_o    <= '0;
            category_o     <= 3'b000;
        end else begin
            result_valid_o <= next_valid;
            drop_o         <= next_drop;
            port_mask_o    <= next_mask;
            category_o     <= next_cat;
        end
    end

endmodule

/* File: uvfc_pkg.sv */
package uvfc_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] UVFC_ADDR_UNK_UCAST   = 12'h320;
    localparam logic [11:0] UVFC_ADDR_UNK_MCAST   = 12'h324;
    localparam logic [11:0] UVFC_ADDR_UNK_VLAN    = 12'h328;
    localparam logic [11:0] UVFC_ADDR_MAC_CTRL0   = 12'h330;
    // Control 1 is byte 1 of the control 0 word
    localparam logic [11:0] UVFC_ADDR_MAC_CTRL1   = 12'h331;
    localparam logic [11:0] UVFC_ADDR_FRAME_STAT  = 12'h338;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int UVFC_FWD_EN_BIT       = 31;
    localparam int UVFC_ALT_BACKOFF_BIT  = 7;
    localparam int UVFC_LEN_CHECK_BIT    = 3;
    localparam int UVFC_FC_DROP_MODE_BIT = 1;
    localparam int UVFC_AGGR_BACKOFF_BIT = 0;
    localparam int UVFC_NO_XCOL_DROP_BIT = 3;
    localparam int UVFC_CTRL1_LANE       = int'(UVFC_ADDR_MAC_CTRL1[1:0]);
    localparam int UVFC_CTRL1_LSB        = 8 * UVFC_CTRL1_LANE;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] UVFC_UNK_RST   = 32'h0000_0000;
    localparam logic [7:0]  UVFC_CTRL0_RST = 8'h0e;
    localparam logic [7:0]  UVFC_CTRL1_RST = 8'hf0;

    // ----------------------------------------------------------------
    // Frame constants
    // ----------------------------------------------------------------
    localparam logic [15:0] UVFC_FC_ETHERTYPE = 16'h8808;
    localparam logic [47:0] UVFC_FC_DA        = 48'h0180_c200_0001;
    localparam logic [15:0] UVFC_LEN_LIMIT    = 16'h05dc;
    localparam logic [4:0]  UVFC_XCOL_LIMIT   = 5'h10;

    localparam logic [31:0] UVFC_UNMAPPED_DATA = 32'h0000_0000;

    typedef enum logic [2:0] {
        UVFC_CAT_VLAN  = 3'b001,
        UVFC_CAT_UCAST = 3'b010,
        UVFC_CAT_MCAST = 3'b100
    } uvfc_cat_e;

endpackage
